// ===== dsrp_pkg.sv
// dsrp_pkg: constants shared by the dual serial register port.
// assumes one 25 mhz system clock; all serial pins are asynchronous to it.
package dsrp_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] CFG_OFFSET = 8'h15; // serial_interface_config
    localparam logic [7:0] CFG_RESET = 8'h00;  // reset value of the config register
    localparam int CFG_HOLD_BIT = 0;           // fast_hold_after_stop
    localparam int CFG_PAIR_BIT = 1;           // i2c pointer/data pair mode

    // ------------------------------------------------------------
    // i2c addressing
    // ------------------------------------------------------------
    localparam logic [6:0] I2C_ADDR_BASE = 7'h30; // strap 2 low, straps 1..0 add in
    localparam logic [6:0] I2C_ADDR_HIGH = 7'h34; // strap 2 high, straps 1..0 ignored
    localparam logic [4:0] MASTER_CODE_TOP = 5'h01; // upper five bits of the master code
    localparam logic [3:0] BYTE_BITS = 4'h8;

    // ------------------------------------------------------------
    // spi frame layout (bit counts from frame start)
    // ------------------------------------------------------------
    localparam logic [11:0] SPI_DIR_BIT = 12'h000;
    localparam logic [11:0] SPI_BURST_BIT = 12'h001;
    localparam logic [11:0] SPI_ADDR_FIRST = 12'h006;
    localparam logic [11:0] SPI_LEN_FIRST = 12'h010;
    localparam logic [11:0] SPI_HDR_BITS = 12'h018;
    localparam logic [11:0] SPI_CNT_MAX = 12'hfff;

    // ------------------------------------------------------------
    // i2c receiver states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        I_IDLE = 3'b000,
        I_ADDR = 3'b001,
        I_PTR = 3'b010,
        I_WDATA = 3'b011,
        I_ACK = 3'b100,
        I_RDATA = 3'b101,
        I_MACK = 3'b110
    } dsrp_i2c_state_t;

endpackage : dsrp_pkg

// ===== dsrp_sync.sv
// dsrp_sync: two-flop synchronisers with edge detection for a bundle of pins.
// assumes each bit is an independent level from outside the clock domain.
`timescale 1ns/1ps
module dsrp_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // raw pins
    input wire logic [W-1:0] din,
    // synchronised level and edges
    output logic [W-1:0] level,
    output logic [W-1:0] rise,
    output logic [W-1:0] fall
);

    // ------------------------------------------------------------
    // synchroniser stages
    // ------------------------------------------------------------
    logic [W-1:0] meta; // first stage, read only by the second
    logic [W-1:0] stage2; // settled level
    logic [W-1:0] stage3; // previous settled level

    // three stages so that edges are seen only on settled values
    always_ff @(posedge clk) begin
        if (reset) begin
            // fill with the pin levels: idle-high pins give no false edge at release
            meta <= din;
            stage2 <= din;
            stage3 <= din;
        end else begin
            meta <= din;
            stage2 <= meta;
            stage3 <= stage2;
        end
    end

    assign level = stage2;
    assign rise = stage2 & ~stage3;
    assign fall = ~stage2 & stage3;

endmodule : dsrp_sync

// ===== dsrp_top.sv
// dsrp_top: i2c or spi slave giving a host access to the converter registers.
// assumes the register bank outside answers reg_rdata combinationally
// from reg_rd_addr, and takes one-cycle write strobes on reg_we.
//
// Overview of operation
// - i2c write data commits at ack rise
// - single read: pointer, repeated start, one byte
// - master ack fetches next byte, nack ends
// - stop clears the register pointer
// - stop restores slow filters, sr keeps them
// - master code 00001xxx is nacked, enters fast
// - fast mode survives repeated starts until stop
// - hold bit keeps fast mode across stop
// - select pin chooses i2c or spi slave
// - miso undriven while chip select high
// - spi mode 0, sample on rising clock
// - first bit direction, second bit burst
// - four header bits are skipped
// - ten-bit address, above 0xff ignored
// - single frame is 32 bits, length ignored
// - burst frame has length-driven byte count
// - miso low when idle, mosi ignored reading
// - burst write increments address, extra dropped
// - burst read stops after count, absent reads zero
// - i2c address from three phase straps
// - device never drives the i2c clock
`timescale 1ns/1ps
module dsrp_top
    import dsrp_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // interface select, high picks spi
    input wire logic serial_mode_select,
    // slave address straps
    input wire logic phase_config_pin0,
    input wire logic phase_config_pin1,
    input wire logic phase_config_pin2,
    // i2c pins (sda open drain)
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // spi pins
    input wire logic spi_clk,
    input wire logic serial_select_n,
    input wire logic mosi,
    output logic miso,
    output logic miso_oe,
    // filter setting for the pad front end
    output logic high_speed_mode,
    // register bank side
    output logic [7:0] reg_rd_addr,
    input wire logic [7:0] reg_rdata,
    output logic reg_we,
    output logic [7:0] reg_waddr,
    output logic [7:0] reg_wdata
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [8:0] pin_raw; // all asynchronous inputs
    logic [8:0] pin_lvl; // settled levels
    logic [8:0] pin_rise; // rising edges
    logic [8:0] pin_fall; // falling edges

    assign pin_raw = {phase_config_pin2, phase_config_pin1, phase_config_pin0,
                      serial_mode_select, serial_select_n, mosi, spi_clk, sda_in, scl_in};

    dsrp_sync #(.W(9)) u_sync (
        .clk(sys_clk),
        .reset(reset),
        .din(pin_raw),
        .level(pin_lvl),
        .rise(pin_rise),
        .fall(pin_fall)
    );

    logic scl_lvl, scl_rise, scl_fall; // i2c clock
    logic sda_lvl, sda_rise, sda_fall; // i2c data
    logic sck_rise, sck_fall; // spi clock edges
    logic mosi_lvl; // spi data in
    logic cs_high; // chip select released
    logic spi_en; // spi chosen
    logic i2c_en; // i2c chosen
    logic [6:0] my_addr; // strapped i2c address

    assign scl_lvl = pin_lvl[0];
    assign scl_rise = pin_rise[0];
    assign scl_fall = pin_fall[0];
    assign sda_lvl = pin_lvl[1];
    assign sda_rise = pin_rise[1];
    assign sda_fall = pin_fall[1];
    assign sck_rise = pin_rise[2];
    assign sck_fall = pin_fall[2];
    assign mosi_lvl = pin_lvl[3];
    assign cs_high = pin_lvl[4];
    assign spi_en = pin_lvl[5];
    assign i2c_en = ~pin_lvl[5];

    assign my_addr = pin_lvl[8] ? I2C_ADDR_HIGH : (I2C_ADDR_BASE | {5'h00, pin_lvl[7:6]});

    // ------------------------------------------------------------
    // shared read path
    // ------------------------------------------------------------
    logic [7:0] cfg; // serial_interface_config contents

    // the config register lives here; the rest comes from the bank
    function automatic logic [7:0] read_byte(input logic [7:0] addr, input logic [7:0] ext,
                                             input logic [7:0] cfg_val);
        read_byte = (addr == CFG_OFFSET) ? cfg_val : ext;
    endfunction : read_byte

    logic [7:0] rd_byte; // byte at the current read address
    assign rd_byte = read_byte(reg_rd_addr, reg_rdata, cfg);

    // ------------------------------------------------------------
    // i2c slave
    // ------------------------------------------------------------
    dsrp_i2c_state_t i_state; // protocol phase
    dsrp_i2c_state_t i_after; // phase after the slave ack
    logic [3:0] i_cnt; // bits of the current byte
    logic [7:0] i_shift; // received or outgoing byte
    logic [7:0] i_ptr; // register pointer
    logic i_last_w; // the acked byte is write data
    logic i_start; // start or repeated start seen
    logic i_stop; // stop seen
    logic i_wr_go; // write strobe from i2c

    assign i_start = i2c_en & scl_lvl & sda_fall;
    assign i_stop = i2c_en & scl_lvl & sda_rise;
    assign i_wr_go = i2c_en & (i_state == I_ACK) & scl_rise & i_last_w;

    // byte-level protocol; every action waits for a settled scl edge, start and stop for a settled sda edge
    always_ff @(posedge sys_clk) begin
        if (reset || !i2c_en) begin
            i_state <= I_IDLE;
            i_after <= I_IDLE;
            i_cnt <= 4'h0;
            i_shift <= 8'h00;
            i_ptr <= 8'h00;
            i_last_w <= 1'b0;
            sda_oe <= 1'b0;
        end else if (i_start) begin
            // a repeated start resumes at the address byte, pointer kept
            i_state <= I_ADDR;
            i_cnt <= 4'h0;
            sda_oe <= 1'b0;
        end else if (i_stop) begin
            i_ptr <= 8'h00;
            i_state <= I_IDLE;
            i_cnt <= 4'h0;
            sda_oe <= 1'b0;
        end else begin
            unique case (i_state)
                I_IDLE: begin
                    // wait for a start; nothing is driven
                    sda_oe <= 1'b0;
                end
                I_ADDR, I_PTR, I_WDATA: begin
                    // msb first, sampled at scl rise
                    if (scl_rise) begin
                        i_shift <= {i_shift[6:0], sda_lvl};
                        i_cnt <= i_cnt + 4'h1;
                    end
                    if (scl_fall && i_cnt == BYTE_BITS) begin
                        i_cnt <= 4'h0;
                        if (i_state == I_ADDR) begin
                            i_last_w <= 1'b0;
                            if (i_shift[7:1] == my_addr) begin
                                sda_oe <= 1'b1;
                                i_after <= i_shift[0] ? I_RDATA : I_PTR;
                                i_state <= I_ACK;
                            end else begin
                                // master code or foreign address: no ack
                                i_state <= I_IDLE;
                            end
                        end else if (i_state == I_PTR) begin
                            i_ptr <= i_shift;
                            i_last_w <= 1'b0;
                            sda_oe <= 1'b1;
                            i_after <= I_WDATA;
                            i_state <= I_ACK;
                        end else begin
                            i_last_w <= 1'b1;
                            sda_oe <= 1'b1;
                            i_after <= cfg[CFG_PAIR_BIT] ? I_PTR : I_WDATA;
                            i_state <= I_ACK;
                        end
                    end
                end
                I_ACK: begin
                    if (i_wr_go && !cfg[CFG_PAIR_BIT]) begin
                        i_ptr <= i_ptr + 8'h01;
                    end
                    if (scl_fall) begin
                        i_state <= i_after;
                        i_cnt <= 4'h0;
                        if (i_after == I_RDATA) begin
                            // first read bit goes out as the ack ends
                            i_shift <= rd_byte;
                            sda_oe <= ~rd_byte[7];
                        end else begin
                            sda_oe <= 1'b0;
                        end
                    end
                end
                I_RDATA: begin
                    if (scl_rise) begin
                        i_cnt <= i_cnt + 4'h1;
                    end
                    if (scl_fall) begin
                        if (i_cnt == BYTE_BITS) begin
                            // release sda for the master's answer
                            sda_oe <= 1'b0;
                            i_cnt <= 4'h0;
                            i_state <= I_MACK;
                        end else begin
                            i_shift <= {i_shift[6:0], 1'b0};
                            sda_oe <= ~i_shift[6];
                        end
                    end
                end
                I_MACK: begin
                    if (scl_rise) begin
                        if (sda_lvl) begin
                            i_state <= I_IDLE;
                        end else begin
                            i_ptr <= i_ptr + 8'h01;
                        end
                    end
                    if (scl_fall) begin
                        i_shift <= rd_byte;
                        sda_oe <= ~rd_byte[7];
                        i_state <= I_RDATA;
                    end
                end
                default: begin
                    i_state <= I_IDLE;
                    sda_oe <= 1'b0;
                end
            endcase
        end
    end

    // sda only ever pulls low
    // no clock line driver
    always_ff @(posedge sys_clk) begin
        sda_out <= 1'b0;
    end

    // ------------------------------------------------------------
    // i2c speed mode
    // ------------------------------------------------------------
    logic i_mcode; // address byte just completed is a master code

    assign i_mcode = (i_state == I_ADDR) & scl_fall & (i_cnt == BYTE_BITS)
                     & (i_shift[7:3] == MASTER_CODE_TOP);

    // hold bit writes are trusted to arrive only in slow mode
    always_ff @(posedge sys_clk) begin
        if (reset || !i2c_en) begin
            high_speed_mode <= 1'b0;
        end else if (i2c_en && i_mcode) begin
            high_speed_mode <= 1'b1;
        end else if (i_stop && !cfg[CFG_HOLD_BIT]) begin
            high_speed_mode <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // spi slave
    // ------------------------------------------------------------
    logic [11:0] s_cnt; // rising edges since frame start
    logic s_dir; // 1 write, 0 read
    logic s_burst; // multiple byte frame
    logic [9:0] s_addr; // current target address
    logic [7:0] s_len; // length field
    logic [8:0] s_bytes; // data bytes handled
    logic [7:0] s_shift; // incoming data
    logic [7:0] s_tx; // outgoing data
    logic s_drive; // shifting read data onto miso
    logic [8:0] s_limit; // bytes allowed in this frame
    logic s_in_range; // still inside the byte count
    logic s_addr_ok; // address within the 8-bit space
    logic s_byte_end; // this rise completes a data byte
    logic s_byte_start; // this fall opens a data byte
    logic s_wr_go; // write strobe from spi

    assign s_limit = s_burst ? ({1'b0, s_len} + 9'h001) : 9'h001;
    assign s_in_range = s_bytes < s_limit;
    assign s_addr_ok = (s_addr[9:8] == 2'b00);
    assign s_byte_end = sck_rise & (s_cnt >= SPI_HDR_BITS) & (s_cnt[2:0] == 3'h7);
    assign s_byte_start = sck_fall & (s_cnt >= SPI_HDR_BITS) & (s_cnt[2:0] == 3'h0);
    assign s_wr_go = spi_en & ~cs_high & s_byte_end & s_dir & s_in_range & s_addr_ok;

    // frame decode; chip select high clears everything
    always_ff @(posedge sys_clk) begin
        if (reset || !spi_en || cs_high) begin
            s_cnt <= 12'h000;
            s_dir <= 1'b0;
            s_burst <= 1'b0;
            s_addr <= 10'h000;
            s_len <= 8'h00;
            s_bytes <= 9'h000;
            s_shift <= 8'h00;
        end else if (sck_rise) begin
            if (s_cnt != SPI_CNT_MAX) begin
                s_cnt <= s_cnt + 12'h001;
            end
            s_shift <= {s_shift[6:0], mosi_lvl};
            if (s_cnt == SPI_DIR_BIT) begin
                s_dir <= mosi_lvl;
            end
            if (s_cnt == SPI_BURST_BIT) begin
                s_burst <= mosi_lvl;
            end
            if (s_cnt >= SPI_ADDR_FIRST && s_cnt < SPI_LEN_FIRST) begin
                s_addr <= {s_addr[8:0], mosi_lvl};
            end
            if (s_cnt >= SPI_LEN_FIRST && s_cnt < SPI_HDR_BITS) begin
                s_len <= {s_len[6:0], mosi_lvl};
            end
            if (s_byte_end) begin
                s_addr <= s_addr + 10'h001;
                if (s_bytes != 9'h1ff) begin
                    s_bytes <= s_bytes + 9'h001;
                end
            end
        end
    end

    // read data leaves on falling edges so the master samples it on rises
    always_ff @(posedge sys_clk) begin
        if (reset || !spi_en || cs_high) begin
            s_tx <= 8'h00;
            s_drive <= 1'b0;
            miso <= 1'b0;
        end else if (s_byte_start) begin
            // stop after count, absent reads zero
            if (!s_dir && s_in_range) begin
                s_tx <= s_addr_ok ? rd_byte : 8'h00;
                miso <= s_addr_ok & rd_byte[7];
                s_drive <= 1'b1;
            end else begin
                s_tx <= 8'h00;
                miso <= 1'b0;
                s_drive <= 1'b0;
            end
        end else if (sck_fall && s_drive) begin
            s_tx <= {s_tx[6:0], 1'b0};
            miso <= s_tx[6];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            miso_oe <= 1'b0;
        end else begin
            miso_oe <= spi_en & ~cs_high;
        end
    end

    // ------------------------------------------------------------
    // register bank access
    // ------------------------------------------------------------
    // read address follows whichever slave is selected
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            reg_rd_addr <= 8'h00;
        end else begin
            reg_rd_addr <= spi_en ? s_addr[7:0] : i_ptr;
        end
    end

    // one write strobe per byte; config writes stay local
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            reg_we <= 1'b0;
            reg_waddr <= 8'h00;
            reg_wdata <= 8'h00;
            cfg <= CFG_RESET;
        end else begin
            reg_we <= 1'b0;
            if (i_wr_go || s_wr_go) begin
                reg_waddr <= i_wr_go ? i_ptr : s_addr[7:0];
                reg_wdata <= i_wr_go ? i_shift : {s_shift[6:0], mosi_lvl};
                if ((i_wr_go ? i_ptr : s_addr[7:0]) == CFG_OFFSET) begin
                    cfg <= i_wr_go ? i_shift : {s_shift[6:0], mosi_lvl};
                end else begin
                    reg_we <= 1'b1;
                end
            end
        end
    end

endmodule : dsrp_top

// ===== dsrp_host_model.sv
// dsrp_host_model: host master driving i2c and spi pins of the port.
// assumes the bench resolves the open-drain sda wire with a pull-up.
`timescale 1ns/1ps
module dsrp_host_model (
    // clock
    input wire logic clk,
    // i2c pins
    output logic scl = 1'b1,
    output logic sda_h = 1'b1,
    input wire logic sda,
    // spi pins
    output logic sck = 1'b0,
    output logic cs_n = 1'b1,
    output logic mosi = 1'b0,
    input wire logic miso
);
    // all pin changes land just after a rising edge
    task automatic w(input int n);
        repeat (n) @(posedge clk);
    endtask : w
    // one i2c bit; the bus is sampled late in the high phase
    task automatic ibit(input logic b, output logic r);
        w(2);
        sda_h <= b;
        w(6);
        scl <= 1'b1;
        w(8);
        r = sda;
        scl <= 1'b0;
    endtask : ibit
    task automatic ibyte(input logic [7:0] d, input logic ma, output logic [7:0] q,
            output logic ack);
        for (int i = 7; i >= 0; i--) begin
            ibit(d[i], q[i]);
        end
        ibit(ma, ack);
    endtask : ibyte
    // start and repeated start share one shape
    task automatic start();
        sda_h <= 1'b1;
        w(4);
        scl <= 1'b1;
        w(8);
        sda_h <= 1'b0;
        w(8);
        scl <= 1'b0;
    endtask : start
    task automatic stop();
        sda_h <= 1'b0;
        w(4);
        scl <= 1'b1;
        w(8);
        sda_h <= 1'b1;
        w(8);
    endtask : stop
    // mode 0, select high between frames
    task automatic spi(input logic [63:0] tx, input int nb, output logic [63:0] rx);
        rx = '0;
        cs_n <= 1'b0;
        w(4);
        for (int i = 63; i > 63 - nb; i--) begin
            mosi <= tx[i];
            w(4);
            sck <= 1'b1;
            w(4);
            rx = {rx[62:0], miso};
            sck <= 1'b0;
        end
        w(4);
        cs_n <= 1'b1;
        mosi <= ~mosi;
        w(8);
    endtask : spi
endmodule : dsrp_host_model

// ===== dsrp_properties.sv
// dsrp_properties: port-level checks of the serial register port.
// assumes a single sys_clk domain; bound into every dsrp_top.
`timescale 1ns/1ps
module dsrp_properties (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // watched ports
    input wire logic serial_mode_select,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_oe,
    input wire logic serial_select_n,
    input wire logic miso,
    input wire logic miso_oe,
    input wire logic high_speed_mode,
    input wire logic reg_we
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    a_we_one_pulse: assert property (reg_we |=> !reg_we)
        else $error("write strobe longer than one cycle");
    a_we_at_ack: assert property (reg_we && !serial_mode_select |-> scl_in)
        else $error("i2c write outside clock high");
    a_miso_idle_off: assert property (serial_select_n [*5] |-> !miso_oe && !miso)
        else $error("miso active while deselected");
    a_i2c_quiet_spi: assert property (serial_mode_select [*5] |-> !sda_oe)
        else $error("sda pulled in spi mode");
    a_spi_quiet_i2c: assert property (!serial_mode_select [*5] |-> !miso_oe)
        else $error("miso driven in i2c mode");
    a_fast_drop_stop: assert property ($fell(high_speed_mode) && !serial_mode_select
            |-> scl_in && sda_in)
        else $error("fast mode left without stop");
    a_fast_code_nack: assert property ($rose(high_speed_mode) |-> !sda_oe)
        else $error("master code acknowledged");
    a_spi_we_sel: assert property (reg_we && serial_mode_select |-> !serial_select_n)
        else $error("spi write while deselected");
    c_i2c_write: cover property (reg_we && !serial_mode_select);
    c_spi_write: cover property (reg_we && serial_mode_select);
    c_fast_entry: cover property ($rose(high_speed_mode));
endmodule : dsrp_properties
bind dsrp_top dsrp_properties u_props (.sys_clk(sys_clk), .reset(reset),
    .serial_mode_select(serial_mode_select), .scl_in(scl_in), .sda_in(sda_in),
    .sda_oe(sda_oe), .serial_select_n(serial_select_n), .miso(miso),
    .miso_oe(miso_oe), .high_speed_mode(high_speed_mode), .reg_we(reg_we));

// ===== dual_serial_register_port_test.sv
// dual_serial_register_port_test: self-checking bench for dsrp_top.
// assumes a combinational register bank model and the host model.
`timescale 1ns/1ps
module dual_serial_register_port_test;
    import dsrp_pkg::*;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic sel = 1'b0;
    logic [2:0] ph;
    logic sda_out, sda_oe, miso, miso_oe, high_speed_mode, reg_we;
    logic scl, sda_h, sck, cs_n, mosi, a;
    logic [7:0] reg_rd_addr, reg_waddr, reg_wdata, r, p, q, b;
    logic [7:0] mem [256];
    logic [7:0] exp_m [256];
    logic [63:0] rx;
    logic [31:0] dw;
    logic [6:0] ad;
    int errors = 0, comparisons = 0, seed = 58, wc = 0, cyc = 0, n;
    wire sda = sda_h & ~(sda_oe & ~sda_out);
    always #20 sys_clk = ~sys_clk;
    // register bank answers reads at once, counts write strobes
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (reg_we) begin
            mem[reg_waddr] <= reg_wdata;
            wc <= wc + 1;
        end
        if (cyc == 60000) begin
            errors++;
            complete_run();
        end
    end
    dsrp_top dut (.sys_clk, .reset, .serial_mode_select(sel), .phase_config_pin0(ph[0]),
        .phase_config_pin1(ph[1]), .phase_config_pin2(ph[2]), .scl_in(scl), .sda_in(sda),
        .sda_out, .sda_oe, .spi_clk(sck), .serial_select_n(cs_n), .mosi, .miso, .miso_oe,
        .high_speed_mode, .reg_rd_addr, .reg_rdata(mem[reg_rd_addr]), .reg_we, .reg_waddr,
        .reg_wdata);
    dsrp_host_model host (.clk(sys_clk), .scl, .sda_h, .sda, .sck, .cs_n, .mosi,
        .miso(miso_oe ? miso : ~miso));
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("FAIL t=%0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic complete_run();
        if (errors == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : complete_run
    task automatic wb(input logic [7:0] d, input logic e);
        host.ibyte(d, 1'b1, r, a);
        chk(8'(a), 8'(e));
    endtask : wb
    task automatic rd(input logic ma, input logic [7:0] e);
        host.ibyte(8'hff, ma, r, a);
        chk(r, e);
    endtask : rd
    task automatic ptr(input logic [7:0] x);
        host.start();
        wb({ad, 1'b0}, 1'b0);
        wb(x, 1'b0);
    endtask : ptr
    function automatic logic [23:0] hdr(logic w, logic m, logic [9:0] x, logic [7:0] l);
        return {w, m, 4'ha, x, l};
    endfunction : hdr
    initial begin
        ph = 3'($random(seed));
        for (int i = 0; i < 256; i++) mem[i] = 8'($random(seed));
        exp_m = mem;
        ad = ph[2] ? I2C_ADDR_HIGH : (I2C_ADDR_BASE | {5'h00, ph[1:0]});
        repeat (16) @(posedge sys_clk);
        reset <= 1'b0;
        host.w(8);
        p = 8'($random(seed)) & 8'h0f;
        ptr(p);
        for (int i = 0; i < 3; i++) begin
            q = 8'($random(seed));
            exp_m[p + i] = q;
            wb(q, 1'b0);
        end
        host.stop();
        for (int i = 0; i < 3; i++) chk(mem[p + i], exp_m[p + i]);
        host.start();
        wb({ad ^ 7'h01, 1'b0}, 1'b1);
        host.stop();
        ptr(p);
        host.start();
        wb({ad, 1'b1}, 1'b0);
        rd(1'b0, exp_m[p]);
        rd(1'b1, exp_m[p + 1]);
        host.stop();
        host.start();
        wb({ad, 1'b1}, 1'b0);
        rd(1'b1, exp_m[0]);
        host.stop();
        ptr(CFG_OFFSET);
        host.start();
        wb({ad, 1'b1}, 1'b0);
        rd(1'b1, CFG_RESET);
        host.stop();
        host.start();
        wb(8'h08 | 8'($random(seed) & 7), 1'b1);
        chk(8'(high_speed_mode), 8'h01);
        host.start();
        wb({ad, 1'b1}, 1'b0);
        rd(1'b1, exp_m[0]);
        chk(8'(high_speed_mode), 8'h01);
        host.stop();
        chk(8'(high_speed_mode), 8'h00);
        for (int k = 1; k >= 0; k--) begin
            ptr(CFG_OFFSET);
            wb(8'(k), 1'b0);
            host.stop();
            host.start();
            wb(8'h0f, 1'b1);
            host.stop();
            chk(8'(high_speed_mode), 8'(k));
        end
        ptr(CFG_OFFSET);
        wb(8'h02, 1'b0);
        host.stop();
        ptr(8'h90);
        q = 8'($random(seed));
        b = 8'($random(seed));
        wb(q, 1'b0);
        wb(8'h70, 1'b0);
        wb(b, 1'b0);
        host.stop();
        chk(mem[8'h90], q);
        chk(mem[8'h70], b);
        chk(mem[8'h91], exp_m[8'h91]);
        sel <= 1'b1;
        host.w(8);
        b = {3'b001, 5'($random(seed))};
        q = 8'($random(seed));
        n = wc;
        host.spi({hdr(1'b1, 1'b0, {2'b00, b}, 8'($random(seed))), q, 32'h0}, 32, rx);
        exp_m[b] = q;
        chk(mem[b], q);
        chk(8'(wc - n), 8'h01);
        chk(8'(miso_oe), 8'h00);
        dw = $random(seed);
        n = wc;
        host.spi({hdr(1'b1, 1'b1, {2'b00, b}, 8'h02), dw, 8'h00}, 56, rx);
        for (int i = 0; i < 3; i++) exp_m[b + i] = dw[31 - 8 * i -: 8];
        for (int i = 0; i < 4; i++) chk(mem[b + i], exp_m[b + i]);
        chk(8'(wc - n), 8'h03);
        host.spi({hdr(1'b0, 1'b1, {2'b00, b}, 8'h01), dw[23:0], 16'h0}, 48, rx);
        chk(rx[23:16], exp_m[b]);
        chk(rx[15:8], exp_m[b + 1]);
        chk(rx[7:0], 8'h00);
        n = wc;
        host.spi({hdr(1'b1, 1'b0, {2'b01, b}, 8'h00), 8'hff, 32'h0}, 32, rx);
        chk(8'(wc - n), 8'h00);
        host.spi({hdr(1'b0, 1'b0, {2'b10, b}, 8'h00), 40'h0}, 32, rx);
        chk(rx[7:0], 8'h00);
        complete_run();
    end
endmodule : dual_serial_register_port_test
